//--- hw/pdfs_top.sv
// Upper port pin function select: registers, boot reset values and pin routing
//
// Operation
// - Bits 7 to 0 of the second low select register always read zero and writes are dropped.
// - Pin 31 field at 15:14 of high register 1: port, data bit 31, A/D trigger, 11 forbidden.
// - Pin 30 field at 13:12 of high register 1: port, data bit 30, interrupt request out.
// - Pin 29 field at 11:10 of high register 1: port, data bit 29, chip select 3 out.
// - Pin 28 field at 9:8 of high register 1: port, data bit 28, chip select 2 out.
// - Pin 27 field at 7:6 of high register 1: port, data bit 27, DMA acknowledge 1 out.
// - Pin 26 field at 5:4 of high register 1: port, data bit 26, DMA acknowledge 0 out.
// - Pin 25 field at 3:2 of high register 1: port, data bit 25, DMA request 1 in.
// - Pin 24 field at 1:0 of high register 1: port, data bit 24, DMA request 0 in.
// - Pin 23 field at 15:14 of high register 2: port, data bit 23, interrupt 7 in, trace sync.
// - Each field's low bit resets to 1 in the ROM-off 16-bit expansion boot, else 0.
`default_nettype none
module pdfs_top #(
    parameter bit FLASH_VERSION = 1'b1,
    parameter int ADDR_W = 8,
    parameter int DATA_W = 16
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic boot_rom_off_16bit,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic [8:0] pin_in,
    output logic [8:0] pin_out,
    output logic [8:0] pin_oe,
    input wire logic [8:0] port_out,
    input wire logic [8:0] port_oe,
    output logic [8:0] port_in,
    input wire logic [8:0] bus_d_out,
    input wire logic [8:0] bus_d_oe,
    output logic [8:0] bus_d_in,
    input wire logic interrupt_request_output,
    input wire logic chip_select_3,
    input wire logic chip_select_2,
    input wire logic dma_acknowledge_1,
    input wire logic dma_acknowledge_0,
    input wire logic trace_sync_out,
    input wire logic trace_sync_oe,
    output logic trace_sync_in,
    output logic adc_external_trigger,
    output logic dma_request_1,
    output logic dma_request_0,
    output logic external_interrupt_7
);

    // Reset release through two flops; assertion stays asynchronous
    logic [1:0] rst_sync_r;
    logic rst_n;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    // Select register state
    logic [15:0] high_sel_1_r;
    logic [15:0] high_sel_1_nxt;
    logic [1:0] pin23_sel_r;
    logic [1:0] pin23_sel_nxt;
    logic strap_done_r;
    logic strap_done_nxt;

    // Address decode
    logic hit_h1;
    logic hit_h2;
    logic hit_l2;

    assign hit_h1 = (reg_addr == pdfs_pkg::OFF_HIGH_SEL_1);
    assign hit_h2 = (reg_addr == pdfs_pkg::OFF_HIGH_SEL_2);
    assign hit_l2 = (reg_addr == pdfs_pkg::OFF_LOW_SEL_2);

    // Next select values; the boot strap is sampled once on the first cycle after
    // release, because an async reset may only load constants. A write in that
    // same cycle still wins so no software update is lost.
    always_comb begin
        high_sel_1_nxt = high_sel_1_r;
        pin23_sel_nxt = pin23_sel_r;
        strap_done_nxt = 1'b1;
        if (!strap_done_r && boot_rom_off_16bit) begin
            high_sel_1_nxt = pdfs_pkg::BOOT16_HIGH_SEL_1;
            pin23_sel_nxt = pdfs_pkg::BOOT16_PIN23_SEL;
        end
        if (reg_wr && hit_h1) begin
            high_sel_1_nxt = reg_wdata[15:0];
        end
        if (reg_wr && hit_h2) begin
            pin23_sel_nxt = reg_wdata[pdfs_pkg::PIN23_SEL_HI:pdfs_pkg::PIN23_SEL_LO];
        end
        // Writes to the low register 2 reserved byte are dropped
    end

    // Register the select state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            high_sel_1_r <= pdfs_pkg::RST_HIGH_SEL_1;
            pin23_sel_r <= pdfs_pkg::RST_PIN23_SEL;
            strap_done_r <= 1'b0;
        end else begin
            high_sel_1_r <= high_sel_1_nxt;
            pin23_sel_r <= pin23_sel_nxt;
            strap_done_r <= strap_done_nxt;
        end
    end

    // Read path: data stand only in the cycle after the read strobe
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    always_comb begin
        rdata_nxt = DATA_W'(pdfs_pkg::RDATA_ZERO);
        if (reg_rd) begin
            if (hit_h1) begin
                rdata_nxt = DATA_W'(high_sel_1_r);
            end else if (hit_h2) begin
                // Only the pin 23 field lives here; other bits read zero
                rdata_nxt = DATA_W'({pin23_sel_r, 14'h0000});
            end else if (hit_l2) begin
                rdata_nxt = DATA_W'(pdfs_pkg::RDATA_ZERO);
            end else begin
                rdata_nxt = DATA_W'(pdfs_pkg::RDATA_ZERO); // Unmapped reads zero
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // Router connection; pin 23 field sits at the bottom of the packed vector
    pdfs_route_if rt ();

    logic [8:0] alt_drive;

    // Peripheral outputs, one slot per pin from pin 23 upward
    assign alt_drive = {
        1'b0, // Pin 31 alternate is an input
        interrupt_request_output,
        chip_select_3,
        chip_select_2,
        dma_acknowledge_1,
        dma_acknowledge_0,
        1'b0, // Pin 25 alternate is an input
        1'b0, // Pin 24 alternate is an input
        1'b0 // Pin 23 alternate is an input
    };

    assign rt.sel = {high_sel_1_r, pin23_sel_r};
    assign rt.port_out = port_out;
    assign rt.port_oe = port_oe;
    assign rt.bus_out = bus_d_out;
    assign rt.bus_oe = bus_d_oe;
    assign rt.alt_out = alt_drive;
    assign rt.trace_out = trace_sync_out;
    assign rt.trace_oe = trace_sync_oe;
    // Masked and ROM-less parts treat the trace code as forbidden
    assign rt.trace_ok = FLASH_VERSION;

    pdfs_router u_router (
        .rt(rt)
    );

    // Pin drive registers; code 11 on a pin without a fourth function drives nothing
    logic [8:0] pin_out_r;
    logic [8:0] pin_out_nxt;
    logic [8:0] pin_oe_r;
    logic [8:0] pin_oe_nxt;

    always_comb begin
        pin_out_nxt = rt.pin_out;
        pin_oe_nxt = rt.pin_oe;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out_r <= 9'h000;
            pin_oe_r <= 9'h000;
        end else begin
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
        end
    end

    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;

    // Inputs towards the port and bus units; unselected pins show zero so a
    // unit never sees a pin that belongs to another function
    logic [8:0] port_in_r;
    logic [8:0] port_in_nxt;
    logic [8:0] bus_d_in_r;
    logic [8:0] bus_d_in_nxt;

    always_comb begin
        port_in_nxt = pin_in & rt.port_sel;
        bus_d_in_nxt = pin_in & rt.bus_sel;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_in_r <= 9'h000;
            bus_d_in_r <= 9'h000;
        end else begin
            port_in_r <= port_in_nxt;
            bus_d_in_r <= bus_d_in_nxt;
        end
    end

    assign port_in = port_in_r;
    assign bus_d_in = bus_d_in_r;

    // Peripheral inputs taken from the pins; idle low when not routed.
    // Costs one cycle of latency, traded for clean registered outputs.
    logic adc_trig_r;
    logic adc_trig_nxt;
    logic dma_request_1_r;
    logic dma_request_1_nxt;
    logic dma_request_0_r;
    logic dma_request_0_nxt;
    logic ext_external_interrupt_7_r;
    logic ext_external_interrupt_7_nxt;
    logic trace_in_r;
    logic trace_in_nxt;

    always_comb begin
        adc_trig_nxt = rt.alt_sel[8] & pin_in[8];
        dma_request_1_nxt = rt.alt_sel[2] & pin_in[2];
        dma_request_0_nxt = rt.alt_sel[1] & pin_in[1];
        ext_external_interrupt_7_nxt = rt.alt_sel[0] & pin_in[0];
        trace_in_nxt = rt.trace_sel & pin_in[0];
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_trig_r <= 1'b0;
            dma_request_1_r <= 1'b0;
            dma_request_0_r <= 1'b0;
            ext_external_interrupt_7_r <= 1'b0;
            trace_in_r <= 1'b0;
        end else begin
            adc_trig_r <= adc_trig_nxt;
            dma_request_1_r <= dma_request_1_nxt;
            dma_request_0_r <= dma_request_0_nxt;
            ext_external_interrupt_7_r <= ext_external_interrupt_7_nxt;
            trace_in_r <= trace_in_nxt;
        end
    end

    assign adc_external_trigger = adc_trig_r;
    assign dma_request_1 = dma_request_1_r;
    assign dma_request_0 = dma_request_0_r;
    assign external_interrupt_7 = ext_external_interrupt_7_r;
    assign trace_sync_in = trace_in_r;

endmodule
`default_nettype wire

//--- shared/pdfs_pkg.sv
// Constants for the upper port pin function select block
`default_nettype none
package pdfs_pkg;
    // Register byte addresses on the plain register port
    localparam logic [7:0] OFF_HIGH_SEL_1 = 8'h00;
    localparam logic [7:0] OFF_HIGH_SEL_2 = 8'h04;
    localparam logic [7:0] OFF_LOW_SEL_2 = 8'h08;
    // Pins handled here: pin 23 up to pin 31
    localparam int NUM_PINS = 9;
    localparam int FIRST_PIN = 23;
    localparam int SEL_W = 2 * NUM_PINS;
    // Field positions of the pin 23 field in the second high register
    localparam int PIN23_SEL_LO = 14;
    localparam int PIN23_SEL_HI = 15;
    // Field positions in the first high register (pin 24 at 1:0 ... pin 31 at 15:14)
    localparam int PIN31_SEL_LO = 14;
    localparam int PIN30_SEL_LO = 12;
    localparam int PIN29_SEL_LO = 10;
    localparam int PIN28_SEL_LO = 8;
    localparam int PIN27_SEL_LO = 6;
    localparam int PIN26_SEL_LO = 4;
    localparam int PIN25_SEL_LO = 2;
    localparam int PIN24_SEL_LO = 0;
    // Select codes
    localparam logic [1:0] CODE_PORT = 2'h0;
    localparam logic [1:0] CODE_BUS = 2'h1;
    localparam logic [1:0] CODE_ALT = 2'h2;
    localparam logic [1:0] CODE_TRACE = 2'h3;
    // Reset values: all zero, low bit of each field set in 16-bit expansion boot
    localparam logic [15:0] RST_HIGH_SEL_1 = 16'h0000;
    localparam logic [15:0] BOOT16_HIGH_SEL_1 = 16'h5555;
    localparam logic [1:0] RST_PIN23_SEL = 2'h0;
    localparam logic [1:0] BOOT16_PIN23_SEL = 2'h1;
    localparam logic [15:0] RDATA_ZERO = 16'h0000;
    // Pins whose alternate function drives the pin (pins 26 to 30)
    localparam logic [8:0] ALT_DRIVES_MASK = 9'h0F8;
endpackage
`default_nettype wire

//--- shared/pdfs_route_if.sv
// Carrier between the select registers and the per-pin router
`default_nettype none
interface pdfs_route_if;
    wire [17:0] sel;
    wire [8:0] port_out;
    wire [8:0] port_oe;
    wire [8:0] bus_out;
    wire [8:0] bus_oe;
    wire [8:0] alt_out;
    wire trace_out;
    wire trace_oe;
    wire trace_ok;
    wire [8:0] pin_out;
    wire [8:0] pin_oe;
    wire [8:0] port_sel;
    wire [8:0] bus_sel;
    wire [8:0] alt_sel;
    wire trace_sel;
    modport ctrl (
        output sel, port_out, port_oe, bus_out, bus_oe, alt_out,
        output trace_out, trace_oe, trace_ok,
        input pin_out, pin_oe, port_sel, bus_sel, alt_sel, trace_sel
    );
    modport route (
        input sel, port_out, port_oe, bus_out, bus_oe, alt_out,
        input trace_out, trace_oe, trace_ok,
        output pin_out, pin_oe, port_sel, bus_sel, alt_sel, trace_sel
    );
endinterface
`default_nettype wire

//--- hw/pdfs_router.sv
// Per-pin function decode and drive multiplexer
`default_nettype none
module pdfs_router (
    pdfs_route_if.route rt
);
    // One decoder per pin; forbidden codes leave the pin undriven
    for (genvar i = 0; i < pdfs_pkg::NUM_PINS; i++) begin : g_pin
        wire [1:0] code;
        wire is_trace;
        assign code = rt.sel[2*i+1:2*i];
        assign rt.port_sel[i] = (code == pdfs_pkg::CODE_PORT);
        assign rt.bus_sel[i] = (code == pdfs_pkg::CODE_BUS);
        assign rt.alt_sel[i] = (code == pdfs_pkg::CODE_ALT);
        if (i == 0) begin : g_trace
            // Trace sync exists only on pin 23 and only where the part allows it
            assign is_trace = (code == pdfs_pkg::CODE_TRACE) && rt.trace_ok;
        end else begin : g_no_trace
            assign is_trace = 1'b0;
        end
        assign rt.pin_out[i] = rt.port_sel[i] ? rt.port_out[i] :
                               rt.bus_sel[i] ? rt.bus_out[i] :
                               is_trace ? rt.trace_out :
                               rt.alt_out[i];
        assign rt.pin_oe[i] = rt.port_sel[i] ? rt.port_oe[i] :
                              rt.bus_sel[i] ? rt.bus_oe[i] :
                              is_trace ? rt.trace_oe :
                              (rt.alt_sel[i] & pdfs_pkg::ALT_DRIVES_MASK[i]);
    end
    assign rt.trace_sel = g_pin[0].is_trace;
endmodule
`default_nettype wire

//--- dv/pdfs_chk.sv
// Assertion checker for the upper port pin function select block
`default_nettype none
module pdfs_chk #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 16
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic [8:0] pin_in,
    input wire logic [8:0] pin_oe,
    input wire logic [8:0] port_in,
    input wire logic [8:0] bus_d_in,
    input wire logic adc_external_trigger,
    input wire logic dma_request_0,
    input wire logic external_interrupt_7,
    input wire logic trace_sync_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Read data stands only in the cycle after a read
    a_rdata_idle_zero: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data without a read");
    a_reserved_reads_zero: assert property (
        $past(reg_rd) && $past(reg_addr) == pdfs_pkg::OFF_LOW_SEL_2 |-> reg_rdata[7:0] == 8'h00)
        else $error("reserved bits read nonzero");
    a_write_read_back: assert property (
        reg_wr && reg_addr == 8'h00 ##1 reg_rd && reg_addr == 8'h00
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("field not read back as written");
    // Peripheral inputs carry the pin level: trigger and request 0 with the pin released, irq 7 without trace sync
    a_trigger_from_pin: assert property (
        adc_external_trigger |-> $past(pin_in[8]) && !pin_oe[8]) else $error("trigger not from pin");
    a_dma_request_0_from_pin: assert property (
        dma_request_0 |-> $past(pin_in[1]) && !pin_oe[1]) else $error("request 0 not from pin");
    a_external_interrupt_7_from_pin: assert property (
        external_interrupt_7 |-> $past(pin_in[0]) && !trace_sync_in) else $error("irq 7 wrong");
    a_inputs_masked: assert property (
        ((port_in | bus_d_in) & ~$past(pin_in)) == 9'h000 && (port_in & bus_d_in) == 9'h000)
        else $error("port or bus input not masked");
    // Pins follow a new field one edge after the write
    a_write_steers_pin: assert property (
        reg_wr && reg_addr == 8'h00 && reg_wdata[1:0] == 2'h2
        |-> ##2 dma_request_0 == $past(pin_in[1]) && !pin_oe[1]) else $error("pin not steered");
endmodule
bind pdfs_top pdfs_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_pdfs_chk (
    .core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in,
    .pin_oe, .port_in, .bus_d_in, .adc_external_trigger, .dma_request_0,
    .external_interrupt_7, .trace_sync_in);
`default_nettype wire

//--- dv/pdfs_pin_world.sv
// Board side of the nine pins: external drive meets the block's own drive
`default_nettype none
module pdfs_pin_world (
    input wire logic [8:0] pin_out,
    input wire logic [8:0] pin_oe,
    input wire logic [8:0] ext_lvl,
    output logic [8:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // A driven pin reads back its own level; a released one shows the board
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire

//--- dv/pdfs_top_tb_top.sv
// Testbench for the upper port pin function select block
`default_nettype none
module pdfs_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] H1 = pdfs_pkg::OFF_HIGH_SEL_1;
    localparam logic [7:0] H2 = pdfs_pkg::OFF_HIGH_SEL_2;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic boot_rom_off_16bit = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [8:0] pin_in, pin_out, pin_oe, port_in, bus_d_in;
    logic [8:0] ext_lvl = 9'h1A5;
    logic [8:0] port_out = 9'h155;
    logic [8:0] port_oe = 9'h0F0;
    logic [8:0] bus_d_out = 9'h0AA;
    logic [8:0] bus_d_oe = 9'h10F;
    logic [4:0] alt_lvl = 5'h16; // Irq out, cs3, cs2, dma_acknowledge_1, dma_acknowledge_0
    logic trace_sync_out = 1'b1;
    logic trace_sync_oe = 1'b1;
    logic trace_sync_in, adc_external_trigger, dma_request_1, dma_request_0, external_interrupt_7;
    int n_mismatch = 0;
    int tests_run = 0;
    logic [15:0] tbl [6] = '{16'h0000, 16'h5555, 16'hAAAA, 16'hFFFF, 16'hE4E4, 16'h1B1B};

    pdfs_top u_pdfs_top (
        .core_clk, .resetn, .boot_rom_off_16bit, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pin_in, .pin_out, .pin_oe, .port_out, .port_oe, .port_in, .bus_d_out,
        .bus_d_oe, .bus_d_in, .interrupt_request_output(alt_lvl[4]),
        .chip_select_3(alt_lvl[3]), .chip_select_2(alt_lvl[2]),
        .dma_acknowledge_1(alt_lvl[1]), .dma_acknowledge_0(alt_lvl[0]), .trace_sync_out,
        .trace_sync_oe, .trace_sync_in, .adc_external_trigger, .dma_request_1,
        .dma_request_0, .external_interrupt_7);
    pdfs_pin_world u_pdfs_pin_world (.pin_out, .pin_oe, .ext_lvl, .pin_in);

    // 250 MHz clock
    initial forever #2 core_clk = ~core_clk;

    task automatic miss(input string m);
        n_mismatch++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) miss($sformatf("word %h, expected %h", got, exp));
    endtask
    task automatic cmp_pins(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp) miss($sformatf("pins %h, expected %h", got, exp));
    endtask
    // Register port: strobes set just after an edge, taken at the next one
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        cmp_word(reg_rdata, e);
        @(posedge core_clk);
    endtask
    // Four edges after release leave room for the two-flop release and strap
    task automatic do_reset(input logic boot);
        resetn <= 1'b0;
        boot_rom_off_16bit <= boot;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask
    // Expected pin view for a word; pin 31 and pin 23 both take bits 15:14
    task automatic check_pins(input logic [15:0] w);
        logic [1:0] c;
        logic [8:0] eo, ed, lv, pi, bi, pk, a9;
        a9 = {1'b0, alt_lvl, 3'h0};
        for (int b = 0; b < 9; b++) begin
            c = (b == 0) ? w[15:14] : w[2*b-2 +: 2];
            eo[b] = (c == 2'h0) ? port_oe[b] : (c == 2'h1) ? bus_d_oe[b]
                : (c == 2'h2) ? (b > 2 && b < 8) : (b == 0) && trace_sync_oe;
            ed[b] = (c == 2'h0) ? port_out[b] : (c == 2'h1) ? bus_d_out[b]
                : (c == 2'h2) ? a9[b] : trace_sync_out;
            lv[b] = eo[b] ? ed[b] : ext_lvl[b];
            pi[b] = (c == 2'h0) && lv[b];
            bi[b] = (c == 2'h1) && lv[b];
            pk[b] = (c == 2'h2) && lv[b];
        end
        @(negedge core_clk);
        cmp_pins(pin_oe, eo);
        cmp_pins(pin_out & eo, ed & eo);
        cmp_pins({7'h00, pin_oe[3], pin_out[3] & eo[3]}, {7'h00, eo[3], ed[3] & eo[3]});
        cmp_pins({8'h00, dma_request_0}, {8'h00, pk[1]});
        cmp_pins(port_in, pi);
        cmp_pins(bus_d_in, bi);
        cmp_pins({adc_external_trigger, 5'h00, dma_request_1, dma_request_0,
            external_interrupt_7}, pk & 9'h107);
        cmp_pins({8'h00, trace_sync_in}, {8'h00, w[15:14] == 2'h3 && lv[0]});
        @(posedge core_clk);
    endtask

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence: boot values, every code on every pin, reserved places
    initial begin
        do_reset(1'b0);
        rd(H1, 16'h0000);
        rd(H2, 16'h0000);
        check_pins(16'h0000);
        do_reset(1'b1);
        rd(H1, 16'h5555);
        rd(H2, 16'h4000);
        check_pins(16'h5555);
        $display("test boot reset done");
        // Trace code is used since the part is the flash version
        for (int k = 0; k < 12; k++) begin
            ext_lvl <= (k < 6) ? 9'h1A5 : 9'h05A;
            // Flip the peripheral drive levels so both pin levels are seen
            alt_lvl <= (k < 6) ? 5'h16 : 5'h09;
            // A read right after each write keeps strobes one edge apart
            wr(H1, tbl[k % 6]);
            rd(H1, tbl[k % 6]);
            wr(H2, tbl[k % 6]);
            rd(H2, tbl[k % 6] & 16'hC000);
            check_pins(tbl[k % 6]);
        end
        $display("test pin codes done");
        // Reserved low byte is written as zero only, as software must
        wr(pdfs_pkg::OFF_LOW_SEL_2, 16'hFF00);
        rd(pdfs_pkg::OFF_LOW_SEL_2, 16'h0000);
        rd(8'h40, 16'h0000);
        rd(H1, 16'h1B1B);
        $display("test reserved done");
        test_done;
    end

    // Watchdog well beyond the roughly 140 cycles the tests need
    initial begin
        repeat (5000) @(posedge core_clk);
        miss("watchdog ran out");
        test_done;
    end
endmodule
`default_nettype wire
